//--- verilog/qdp_pkg.sv
/*
 * Shared constants and types for the quad-pumped data phase block.
 * Assumes a 10 MHz core clock and a bus clock of 800 ns that is sampled, not used as a clock.
 */
// What this block does
// - Data path is 64 lines wide, all active low, shared by every agent.
// - The driving agent asserts data-valid low for each valid data transfer.
// - Four data words are presented within every common bus clock period.
// - Receiver captures on falling edges of positive then negative strobe, alternating.
// - Each 16-line group has its own strobe pair and inversion line, index by position.
// - Inversion lines travel with their group's data, timed by the same strobes.
// - An active inversion line means the receiver flips the group back before use.
// - Driver inverts a group when more than half its lines would be low.
// - Inversion index 3 covers bits 63:48 down to index 0 covering bits 15:0.
// - The driving agent holds data-bus-busy low while it uses the data bus.
// - No agent takes the data bus until the owner releases data-bus-busy.
// - In multi-clock transfers the driver may drop data-valid to insert idle clocks.
// - All agents take timing from the differential bus clock pair.
package qdp_pkg;

   localparam int DATA_W    = 64;
   localparam int GROUP_W   = 16;
   localparam int GROUPS    = 4;
   localparam int BEATS     = 4;
   localparam int MCLK_NS   = 100;
   localparam int BCLK_NS   = 800;
   localparam int PHASES    = BCLK_NS / MCLK_NS;
   localparam int INV_LIMIT = GROUP_W / 2;
   localparam int BUF_DEPTH = 2;

   localparam logic [2:0] LAST_PHASE = 3'(PHASES - 1);
   localparam logic [2:0] BEATS_DONE = 3'(BEATS);
   localparam logic       PIN_IDLE   = 1'b1;

   // One bus clock worth of payload: four 64-bit words.
   typedef logic [BEATS-1:0][DATA_W-1:0] line_t;

   typedef struct packed {
      logic  last;
      line_t words;
   } tx_line_t;

   // Every pin sampled from the bus, in one bundle for the synchroniser.
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic              valid_n;
      logic [GROUPS-1:0] spos_n;
      logic [GROUPS-1:0] sneg_n;
      logic [GROUPS-1:0] inv_n;
      logic              busy_n;
      logic              clk_p;
      logic              clk_n;
   } pins_t;

   typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_GAP} tx_state_t;

endpackage : qdp_pkg

//--- verilog/quad_data_phase.sv
/*
 * Data-phase engine of a shared system bus: drives and receives quad-pumped,
 * group-inverted data with valid and busy handshakes.
 * Assumes every bus pin, including the bus clock pair, is asynchronous to mclk_i and
 * that the bus clock is at least eight core clocks long; pins are resolved outside.
 */
module quad_data_phase
   import qdp_pkg::*;
(
   input  wire logic                        mclk_i,
   input  wire logic                        reset_i,
   input  wire logic                        bus_clk_p_i,
   input  wire logic                        bus_clk_n_i,
   input  wire logic [qdp_pkg::DATA_W-1:0]  data_i,
   output logic      [qdp_pkg::DATA_W-1:0]  data_o,
   output logic                             data_oe_o,
   input  wire logic                        data_valid_n_i,
   output logic                             data_valid_n_o,
   output logic                             data_valid_oe_o,
   input  wire logic [qdp_pkg::GROUPS-1:0]  data_strobe_pos_n_i,
   output logic      [qdp_pkg::GROUPS-1:0]  data_strobe_pos_n_o,
   output logic                             data_strobe_pos_oe_o,
   input  wire logic [qdp_pkg::GROUPS-1:0]  data_strobe_neg_n_i,
   output logic      [qdp_pkg::GROUPS-1:0]  data_strobe_neg_n_o,
   output logic                             data_strobe_neg_oe_o,
   input  wire logic [qdp_pkg::GROUPS-1:0]  group_invert_n_i,
   output logic      [qdp_pkg::GROUPS-1:0]  group_invert_n_o,
   output logic                             group_invert_oe_o,
   input  wire logic                        data_bus_busy_n_i,
   output logic                             data_bus_busy_n_o,
   output logic                             data_bus_busy_oe_o,
   input  wire logic                        tx_valid_i,
   input  wire qdp_pkg::tx_line_t           tx_line_i,
   output logic                             tx_ready_o,
   output logic                             rx_valid_o,
   output qdp_pkg::line_t                   rx_line_o
);
   import qdp_pkg::*;

   localparam int PTR_W = $clog2(BUF_DEPTH);

   pins_t                  pins_in;
   pins_t                  sync1_q;
   pins_t                  sync2_q;
   logic                   bclk_prev_q;
   logic                   bclk_rise;
   logic [2:0]             phase_q;
   tx_line_t               buf_q [BUF_DEPTH];
   logic [PTR_W-1:0]       wr_ptr_q;
   logic [PTR_W-1:0]       rd_ptr_q;
   logic [PTR_W:0]         cnt_q;
   logic [PTR_W:0]         cnt_d;
   logic                   ready_q;
   logic                   push;
   logic                   load;
   tx_line_t               head;
   tx_state_t              state_q;
   tx_line_t               cur_q;
   logic                   own_q;
   logic                   busy_n_q;
   logic                   valid_n_q;
   logic [DATA_W-1:0]      data_q;
   logic [GROUPS-1:0]      inv_n_q;
   logic [GROUPS-1:0]      spos_n_q;
   logic [GROUPS-1:0]      sneg_n_q;
   logic [DATA_W-1:0]      beat_word;
   logic [DATA_W-1:0]      enc_data;
   logic [GROUPS-1:0]      enc_inv_n;
   logic                   pos_low;
   logic                   neg_low;
   logic [GROUPS-1:0]      done;
   logic                   all_done;
   logic                   valid_beat_q;
   logic                   rx_valid_q;
   line_t                  rx_line_q;
   wire  [BEATS-1:0][DATA_W-1:0] rx_asm;

   // Encode one group: if more than half the lines would sit low, send it flipped.
   function automatic logic [GROUP_W:0] encode_grp(input logic [GROUP_W-1:0] w);
      logic [4:0] ones;
      ones = 5'($countones(w));
      if (ones > 5'(INV_LIMIT)) begin
         return {1'b0, w};
      end
      return {1'b1, ~w};
   endfunction : encode_grp

   // All bus pins are asynchronous, so they pass two flip-flops as one bundle.
   assign pins_in = '{data: data_i, valid_n: data_valid_n_i, spos_n: data_strobe_pos_n_i,
                      sneg_n: data_strobe_neg_n_i, inv_n: group_invert_n_i,
                      busy_n: data_bus_busy_n_i, clk_p: bus_clk_p_i, clk_n: bus_clk_n_i};

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         sync1_q <= '1;
         sync2_q <= '1;
      end else begin
         sync1_q <= pins_in;
         sync2_q <= sync1_q;
      end
   end

   assign bclk_rise = sync2_q.clk_p & ~bclk_prev_q & ~sync2_q.clk_n;

   // The phase counter divides each bus clock into four beat slots of two core clocks.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         bclk_prev_q <= 1'b0;
         phase_q     <= LAST_PHASE;
      end else begin
         bclk_prev_q <= sync2_q.clk_p;
         if (bclk_rise) begin
            phase_q <= 3'h0;
         end else if (phase_q != LAST_PHASE) begin
            phase_q <= phase_q + 3'h1;
         end
      end
   end

   // Two-entry buffer; the engine drains it only on bus clock edges, so it really fills.
   assign push  = tx_valid_i & ready_q;
   assign head  = buf_q[rd_ptr_q];
   assign cnt_d = cnt_q + (PTR_W+1)'(push) - (PTR_W+1)'(load);

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q    <= '0;
         ready_q  <= 1'b0;
      end else begin
         if (push) begin
            buf_q[wr_ptr_q] <= tx_line_i;
            wr_ptr_q        <= wr_ptr_q + PTR_W'(1);
         end
         if (load) begin
            rd_ptr_q <= rd_ptr_q + PTR_W'(1);
         end
         cnt_q   <= cnt_d;
         ready_q <= (cnt_d < (PTR_W+1)'(BUF_DEPTH));
      end
   end

   assign load = bclk_rise && (cnt_q != '0) &&
                 ((state_q == TX_IDLE && sync2_q.busy_n) ||
                  (state_q == TX_SEND && !cur_q.last) || state_q == TX_GAP);

   // Busy and valid change only on bus clock edges.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         state_q   <= TX_IDLE;
         busy_n_q  <= PIN_IDLE;
         valid_n_q <= PIN_IDLE;
         cur_q     <= '0;
      end else if (bclk_rise) begin
         if (load) begin
            cur_q <= head;
         end
         case (state_q)
            TX_IDLE: begin
               if (load) begin
                  state_q   <= TX_SEND;
                  busy_n_q  <= 1'b0;
                  valid_n_q <= 1'b0;
               end
            end
            TX_SEND: begin
               if (cur_q.last) begin
                  state_q   <= TX_IDLE;
                  busy_n_q  <= PIN_IDLE;
                  valid_n_q <= PIN_IDLE;
               end else if (load) begin
                  valid_n_q <= 1'b0;
               end else begin
                  state_q   <= TX_GAP;
                  valid_n_q <= PIN_IDLE;
               end
            end
            TX_GAP: begin
               if (load) begin
                  state_q   <= TX_SEND;
                  valid_n_q <= 1'b0;
               end
            end
            default: begin
               state_q <= TX_IDLE;
            end
         endcase
      end
   end

   // The fourth strobe of a line falls on the closing bus clock edge, so the pins stay
   // driven one core clock past busy; dropping them on that edge would cut the last beat.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         own_q <= 1'b0;
      end else if (load && state_q == TX_IDLE) begin
         own_q <= 1'b1;
      end else if (state_q == TX_IDLE && busy_n_q == PIN_IDLE) begin
         own_q <= 1'b0;
      end
   end

   assign beat_word = cur_q.words[phase_q[2:1]];

   for (genvar g = 0; g < GROUPS; g++) begin : g_enc
      assign {enc_inv_n[g], enc_data[g*GROUP_W +: GROUP_W]} =
         encode_grp(beat_word[g*GROUP_W +: GROUP_W]);
   end

   // Data changes at even phases and strobes fall one clock later, giving setup and hold.
   assign pos_low = (state_q == TX_SEND) &&
                    (phase_q == 3'h1 || phase_q == 3'h2 || phase_q == 3'h5 || phase_q == 3'h6);
   assign neg_low = (state_q == TX_SEND) &&
                    (phase_q == 3'h3 || phase_q == 3'h4 || phase_q == 3'h7);

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         data_q   <= '1;
         inv_n_q  <= '1;
         spos_n_q <= '1;
         sneg_n_q <= '1;
      end else begin
         if (state_q == TX_SEND && !phase_q[0]) begin
            data_q  <= enc_data;
            inv_n_q <= enc_inv_n;
         end
         spos_n_q <= {GROUPS{~pos_low}};
         sneg_n_q <= {GROUPS{~neg_low}};
      end
   end

   assign data_o               = data_q;
   assign data_oe_o            = own_q;
   assign group_invert_n_o     = inv_n_q;
   assign group_invert_oe_o    = own_q;
   assign data_strobe_pos_n_o  = spos_n_q;
   assign data_strobe_pos_oe_o = own_q;
   assign data_strobe_neg_n_o  = sneg_n_q;
   assign data_strobe_neg_oe_o = own_q;
   assign data_valid_n_o       = valid_n_q;
   assign data_valid_oe_o      = own_q;
   assign data_bus_busy_n_o    = busy_n_q;
   assign data_bus_busy_oe_o   = own_q;
   assign tx_ready_o           = ready_q;

   // Receive side: each group counts its own beats, so skew between groups is tolerated.
   for (genvar g = 0; g < GROUPS; g++) begin : g_rx
      logic                           prev_p_q;
      logic                           prev_n_q;
      logic [2:0]                     cnt_q;
      logic [BEATS-1:0][GROUP_W-1:0]  beats_q;
      logic                           take;
      logic [GROUP_W-1:0]             pin_grp;
      // even beats on positive, odd on negative
      assign take = !own_q && cnt_q != BEATS_DONE &&
                    ((prev_p_q && !sync2_q.spos_n[g] && !cnt_q[0]) ||
                     (prev_n_q && !sync2_q.sneg_n[g] && cnt_q[0]));
      assign pin_grp = sync2_q.data[g*GROUP_W +: GROUP_W];
      assign done[g] = (cnt_q == BEATS_DONE);

      always_ff @(posedge mclk_i) begin
         if (reset_i) begin
            prev_p_q <= PIN_IDLE;
            prev_n_q <= PIN_IDLE;
            cnt_q    <= 3'h0;
            beats_q  <= '0;
         end else begin
            prev_p_q <= sync2_q.spos_n[g];
            prev_n_q <= sync2_q.sneg_n[g];
            if (all_done || own_q) begin
               cnt_q <= 3'h0;
            end else if (take) begin
               beats_q[cnt_q[1:0]] <= sync2_q.inv_n[g] ? ~pin_grp : pin_grp;
               cnt_q               <= cnt_q + 3'h1;
            end
         end
      end

      for (genvar b = 0; b < BEATS; b++) begin : g_beat
         assign rx_asm[b][g*GROUP_W +: GROUP_W] = beats_q[b];
      end
   end

   assign all_done = &done;

   // Valid is sampled with the first beat, which arrives well inside the data clock.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         valid_beat_q <= 1'b0;
         rx_valid_q   <= 1'b0;
         rx_line_q    <= '0;
      end else begin
         if (g_rx[0].take && g_rx[0].cnt_q == 3'h0) begin
            valid_beat_q <= ~sync2_q.valid_n;
         end
         rx_valid_q <= all_done && valid_beat_q;
         if (all_done) begin
            rx_line_q <= rx_asm;
         end
      end
   end

   assign rx_valid_o = rx_valid_q;
   assign rx_line_o  = rx_line_q;

   property p_busy_with_valid;
      @(posedge mclk_i) disable iff (reset_i)
      !valid_n_q |-> !busy_n_q && own_q;
   endproperty
   a_busy_with_valid: assert property (p_busy_with_valid) else $error("valid without busy");

   property p_valid_driven;
      @(posedge mclk_i) disable iff (reset_i)
      $fell(valid_n_q) |-> data_valid_oe_o && state_q == TX_SEND;
   endproperty
   a_valid_driven: assert property (p_valid_driven) else $error("valid not driven");

   property p_four_beats;
      @(posedge mclk_i) disable iff (reset_i)
      (state_q == TX_SEND && phase_q == 3'h1) |=> !spos_n_q[0] ##2 !sneg_n_q[0] ##2
         !spos_n_q[0] ##2 !sneg_n_q[0];
   endproperty
   a_four_beats: assert property (p_four_beats) else $error("fewer than four beats");

   property p_strobe_alternate;
      @(posedge mclk_i) disable iff (reset_i)
      $fell(spos_n_q[0]) |-> ##2 $fell(sneg_n_q[0]);
   endproperty
   a_strobe_alternate: assert property (p_strobe_alternate) else $error("no alternation");

   property p_inv_with_data;
      @(posedge mclk_i) disable iff (reset_i)
      $changed(inv_n_q) |-> $past(state_q == TX_SEND && !phase_q[0]);
   endproperty
   a_inv_with_data: assert property (p_inv_with_data) else $error("inversion off slot");

   property p_inv_majority;
      @(posedge mclk_i) disable iff (reset_i)
      own_q |-> (inv_n_q[3] ? $countones(data_q[63:48]) >= 8 : $countones(data_q[63:48]) > 8);
   endproperty
   a_inv_majority: assert property (p_inv_majority) else $error("bad inversion choice");

   property p_claim_free;
      @(posedge mclk_i) disable iff (reset_i)
      $rose(own_q) |-> $past(sync2_q.busy_n);
   endproperty
   a_claim_free: assert property (p_claim_free) else $error("bus taken while busy");

   property p_gap_idle;
      @(posedge mclk_i) disable iff (reset_i)
      state_q == TX_GAP |-> valid_n_q && !busy_n_q && spos_n_q[0] ##1 sneg_n_q[0];
   endproperty
   a_gap_idle: assert property (p_gap_idle) else $error("gap clock not idle");

   property p_rx_valid_only;
      @(posedge mclk_i) disable iff (reset_i)
      rx_valid_q |-> $past(valid_beat_q) && $past(all_done);
   endproperty
   a_rx_valid_only: assert property (p_rx_valid_only) else $error("rx without valid");

endmodule : quad_data_phase

//--- tb/bus_agent_model.sv
/*
 * Far-side bus agent: makes the free-running bus clock, sends lines and captures the block's.
 * Assumes pins that nobody drives float high through pull-ups.
 */
module bus_agent_model
   import qdp_pkg::*;
(
   output logic                            bus_clk_p_i,
   output logic                            bus_clk_n_i,
   output logic      [qdp_pkg::DATA_W-1:0] data_i,
   output logic                            data_valid_n_i,
   output logic      [qdp_pkg::GROUPS-1:0] data_strobe_pos_n_i,
   output logic      [qdp_pkg::GROUPS-1:0] data_strobe_neg_n_i,
   output logic      [qdp_pkg::GROUPS-1:0] group_invert_n_i,
   output logic                            data_bus_busy_n_i,
   input  wire logic [qdp_pkg::DATA_W-1:0] data_o,
   input  wire logic                       data_oe_o,
   input  wire logic                       data_valid_n_o,
   input  wire logic                       data_valid_oe_o,
   input  wire logic [qdp_pkg::GROUPS-1:0] data_strobe_pos_n_o,
   input  wire logic                       data_strobe_pos_oe_o,
   input  wire logic [qdp_pkg::GROUPS-1:0] data_strobe_neg_n_o,
   input  wire logic                       data_strobe_neg_oe_o,
   input  wire logic [qdp_pkg::GROUPS-1:0] group_invert_n_o,
   input  wire logic                       group_invert_oe_o,
   input  wire logic                       data_bus_busy_n_o,
   input  wire logic                       data_bus_busy_oe_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic        m_oe = 1'b0, m_valid_n = 1'b1, m_busy_n = 1'b1, own = 1'b0;
   logic [63:0] m_data = '1;
   logic [3:0]  m_spos = '1, m_sneg = '1, m_inv = '1;
   logic [1:0]  beat = 2'd0;
   logic [67:0] cap_q[$];

   // The block wins while it owns the bus; a released line is pulled high.
   assign data_i = data_oe_o ? data_o : (m_oe ? m_data : '1);
   assign data_valid_n_i = data_valid_oe_o ? data_valid_n_o : (m_oe ? m_valid_n : 1'b1);
   assign data_strobe_pos_n_i = data_strobe_pos_oe_o ? data_strobe_pos_n_o : m_spos;
   assign data_strobe_neg_n_i = data_strobe_neg_oe_o ? data_strobe_neg_n_o : m_sneg;
   assign group_invert_n_i = group_invert_oe_o ? group_invert_n_o : (m_oe ? m_inv : '1);
   assign data_bus_busy_n_i = data_bus_busy_oe_o ? data_bus_busy_n_o : m_busy_n;
   assign bus_clk_n_i = ~bus_clk_p_i;

   initial begin
      bus_clk_p_i = 1'b0;
      #37;
      forever #400 bus_clk_p_i = ~bus_clk_p_i;
   end

   // one line per bus clock; called on a bus clock rise.
   task automatic send(input qdp_pkg::line_t w, input logic vld, input logic last);
      m_oe = 1'b1;
      m_busy_n = 1'b0;
      m_valid_n = ~vld;
      for (int k = 0; k < 4; k++) begin
         for (int g = 0; g < 4; g++) begin
            m_inv[g] = ($countones(w[k][16*g +: 16]) <= 8);
            m_data[16*g +: 16] = m_inv[g] ? ~w[k][16*g +: 16] : w[k][16*g +: 16];
         end
         if (k[0]) m_spos = '1; else m_sneg = '1;
         #100;
         if (k[0]) m_sneg = '0; else m_spos = '0;
         #100;
      end
      if (last) begin
         #200;
         m_sneg = '1;
         m_oe = 1'b0;
         m_busy_n = 1'b1;
         m_valid_n = 1'b1;
      end
   endtask : send

   // capture the block's lines; the whole line follows valid at beat 0.
   always @(negedge data_strobe_pos_n_i[0] or negedge data_strobe_neg_n_i[0]) begin
      if (beat == 2'd0) own = data_oe_o & ~data_valid_n_i;
      if (own === 1'b1) cap_q.push_back({group_invert_n_i, data_i});
      beat++;
   end
endmodule : bus_agent_model

//--- tb/testbench.sv
/*
 * Self-checking bench for quad_data_phase against a far-side bus agent.
 * Assumes the agent resolves every pin and makes the 800 ns bus clock.
 */
module testbench;
   import qdp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk_i = 1'b0, reset_i = 1'b1, tx_valid_i = 1'b0;
   tx_line_t    tx_line_i = '0;
   logic        bus_clk_p_i, bus_clk_n_i, data_valid_n_i, data_bus_busy_n_i, tx_ready_o;
   logic [63:0] data_i, data_o;
   logic [3:0]  data_strobe_pos_n_i, data_strobe_neg_n_i, group_invert_n_i;
   logic [3:0]  data_strobe_pos_n_o, data_strobe_neg_n_o, group_invert_n_o;
   logic        data_oe_o, data_valid_n_o, data_valid_oe_o, data_strobe_pos_oe_o;
   logic        data_strobe_neg_oe_o, group_invert_oe_o, data_bus_busy_n_o;
   logic        data_bus_busy_oe_o, rx_valid_o;
   line_t       rx_line_o, l_a, l_b, l_c, rx_q[$];
   int          n_errors = 0, n_tests = 0, cyc = 0;

   quad_data_phase dut_u (.mclk_i, .reset_i, .bus_clk_p_i, .bus_clk_n_i, .data_i, .data_o,
      .data_oe_o, .data_valid_n_i, .data_valid_n_o, .data_valid_oe_o, .data_strobe_pos_n_i,
      .data_strobe_pos_n_o, .data_strobe_pos_oe_o, .data_strobe_neg_n_i, .data_strobe_neg_n_o,
      .data_strobe_neg_oe_o, .group_invert_n_i, .group_invert_n_o, .group_invert_oe_o,
      .data_bus_busy_n_i, .data_bus_busy_n_o, .data_bus_busy_oe_o, .tx_valid_i, .tx_line_i,
      .tx_ready_o, .rx_valid_o, .rx_line_o);
   bus_agent_model agent_u (.bus_clk_p_i, .bus_clk_n_i, .data_i, .data_valid_n_i,
      .data_strobe_pos_n_i, .data_strobe_neg_n_i, .group_invert_n_i, .data_bus_busy_n_i,
      .data_o, .data_oe_o, .data_valid_n_o, .data_valid_oe_o, .data_strobe_pos_n_o,
      .data_strobe_pos_oe_o, .data_strobe_neg_n_o, .data_strobe_neg_oe_o, .group_invert_n_o,
      .group_invert_oe_o, .data_bus_busy_n_o, .data_bus_busy_oe_o);

   always #50 mclk_i = ~mclk_i;

   // Received lines are sampled mid-cycle, where the pulse has settled.
   always @(negedge mclk_i) if (rx_valid_o === 1'b1) rx_q.push_back(rx_line_o);

   // The block must never drive while the agent holds the bus.
   always @(negedge mclk_i) if (agent_u.m_oe === 1'b1) chk_bit("clash", 1'b0, data_oe_o);

   // A hang ends the run as a failure.
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 30000) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit

   task automatic chk_line(input string what, input line_t exp, input line_t got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_line

   // Offer a line and hold it until the edge that takes it.
   task automatic offer(input line_t w, input logic last);
      @(posedge mclk_i);
      #1 tx_valid_i = 1'b1;
      tx_line_i = {last, w};
      for (int i = 0; i < 3000 && tx_ready_o !== 1'b1; i++) @(posedge mclk_i) #1;
      @(posedge mclk_i);
      #1 tx_valid_i = 1'b0;
   endtask : offer

   task automatic wait_cap(input int n);
      for (int i = 0; i < 400 && agent_u.cap_q.size() < n; i++) @(posedge mclk_i);
   endtask : wait_cap

   // Decode four captured beats and judge polarity choice and restored data.
   task automatic chk_cap(input line_t w);
      logic [67:0] c;
      logic [15:0] t;
      for (int k = 0; k < 4; k++) begin
         c = agent_u.cap_q.size() ? agent_u.cap_q.pop_front() : 'x;
         for (int g = 0; g < 4; g++) begin
            t = w[k][16*g +: 16];
            chk_bit("tx invert", $countones(t) <= 8, c[64+g]);
            chk_line("tx data", {240'h0, t}, {240'h0, c[64+g] ? ~c[16*g +: 16] : c[16*g +: 16]});
         end
      end
   endtask : chk_cap

   task automatic t_reset();
      repeat (8) @(posedge mclk_i);
      #1 reset_i = 1'b0;
      chk_bit("oe in reset", 1'b0, data_oe_o);
      chk_bit("ready in reset", 1'b0, tx_ready_o);
      repeat (2) @(posedge mclk_i);
      #1 chk_bit("ready after reset", 1'b1, tx_ready_o);
      agent_u.beat = 2'd0;
      agent_u.cap_q.delete();
   endtask : t_reset

   // Two valid lines back to back, then one without valid that must vanish.
   task automatic t_rx();
      @(posedge bus_clk_p_i);
      agent_u.send(l_a, 1'b1, 1'b0);
      agent_u.send(l_b, 1'b1, 1'b0);
      agent_u.send(l_c, 1'b0, 1'b1);
      repeat (20) @(posedge mclk_i);
      chk_bit("rx count", 1'b1, rx_q.size() == 2);
      chk_line("rx first", l_a, rx_q.size() ? rx_q.pop_front() : 'x);
      chk_line("rx second", l_b, rx_q.size() ? rx_q.pop_front() : 'x);
   endtask : t_rx

   // Fill the buffer while the agent owns the bus; three lines follow its release.
   task automatic t_tx();
      fork
         begin
            @(posedge bus_clk_p_i);
            agent_u.send(l_b, 1'b1, 1'b0);
            agent_u.send(l_a, 1'b1, 1'b1);
         end
         begin
            wait (data_bus_busy_n_i === 1'b0);
            offer(l_c, 1'b0);
            offer(l_a, 1'b0);
            chk_bit("ready when full", 1'b0, tx_ready_o);
            offer(l_b, 1'b1);
         end
      join
      wait_cap(12);
      repeat (20) @(posedge mclk_i);
      chk_cap(l_c);
      chk_cap(l_a);
      chk_cap(l_b);
      chk_bit("busy released", 1'b1, data_bus_busy_n_i);
      chk_bit("own lines ignored", 1'b1, rx_q.size() == 2);
      chk_line("rx agent first", l_b, rx_q.size() ? rx_q.pop_front() : 'x);
      chk_line("rx agent last", l_a, rx_q.size() ? rx_q.pop_front() : 'x);
   endtask : t_tx

   // Two idle clocks between two lines keep the bus but drop valid.
   task automatic t_gap();
      offer(l_a, 1'b0);
      wait_cap(4);
      repeat (12) @(posedge mclk_i);
      chk_bit("busy in gap", 1'b0, data_bus_busy_n_i);
      chk_bit("valid in gap", 1'b1, data_valid_n_i);
      offer(l_c, 1'b1);
      wait_cap(8);
      repeat (20) @(posedge mclk_i);
      chk_cap(l_a);
      chk_cap(l_c);
      chk_bit("oe after last", 1'b0, data_oe_o);
   endtask : t_gap

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop

   // Word 0 mixes 8, 9, 0 and 16 asserted lines per group.
   initial begin
      l_a = {64'h8000_0001_fffe_7fff, 64'h0123_4567_89ab_cdef, 64'hfedc_ba98_7654_3210,
             64'hffff_0000_01ff_00ff};
      l_b = ~l_a;
      l_c = {4{64'h5a5a_ffff_0001_fff0}};
      t_reset();
      t_rx();
      t_tx();
      t_gap();
      report_and_stop();
   end
endmodule : testbench
